// ---- pkg/cvp_defs.svh ----
/*
 * Constants of the cell voltage protection sequencer: timebase, scan
 * periods, lockout scan count, hysteresis and reset values.
 * Assumes a 200 MHz clock and 12-bit cell codes of 1.8 V * 8/3 full scale.
 */
// Notes on behaviour
// - Scan every 32ms; after idle period 256ms; after another idle period 512ms.
// - Scan rate follows only time since current was seen, never pending faults.
// - One qualification timer for all cells; fault only if it persists throughout.
// - Each delay is 2-bit scale (us, ms, s, min) plus 10-bit count.
// - Each voltage threshold and release level is its own 12-bit setting.
// - Qualified overvoltage sets high-cell flag; automatic mode opens charge switch.
// - Release after all cells stay below release level for the same delay.
// - Timers tick freely, so second settings may stretch up to double.
// - Charging cell above done level flags; clears below level minus 117mV.
// - Overvoltage lockout sets flag, trips fuse, opens charge paths regardless.
// - Optionally close charge switch during overvoltage while discharging.
// - Qualified undervoltage sets low-cell flag; automatic mode opens discharge switch.
// - With precharge enabled, a low cell routes charge through the precharge switch.
// - After release level plus delay plus 3s, probe load every 256ms.
// - Probe high with cells above release clears low-cell flag, recloses discharge.
// - Qualified sleep sets sleep bit; automatic mode opens switches and sleeps.
// - Five scans below lockout set flag and shutdown; power down or open discharge.
// - Optionally close discharge switch during undervoltage while charging.
// - Scan covers die and two sensors; sensor two may watch the switches.
// - One temperature gain: 0 is gain 2 at 0.9V, 1 is gain 1.
`ifndef CVP_DEFS_SVH
`define CVP_DEFS_SVH
`define CVP_CLK_NS 5
`define CVP_CYC_PER_US (1000 / `CVP_CLK_NS)
`define CVP_US_PER_MS 1000
`define CVP_MS_PER_S 1000
`define CVP_S_PER_MIN 60
`define CVP_SCAN_NORM_MS 32
`define CVP_SCAN_IDLE_MS 256
`define CVP_SCAN_DOZE_MS 512
`define CVP_PROBE_PERIOD_MS 256
`define CVP_UV_EXTRA_S 3
`define CVP_LOCKOUT_SCANS 5
`define CVP_EOC_HYST_MV 117
`define CVP_EOC_HYST_CODE ((`CVP_EOC_HYST_MV * 4095 * 3) / (1800 * 8))
`define CVP_DLY_SCALE_MSB 11
`define CVP_DLY_SCALE_LSB 10
`define CVP_THERMAL_INPUT_GAIN_RST 1'b0
`endif

// ---- pkg/cvp_pkg.sv ----
/*
 * Types of the cell voltage protection sequencer.
 * Assumes nothing beyond the constants header.
 */
package cvp_pkg;
    typedef enum logic [1:0] {SCAN_NORMAL, SCAN_IDLE, SCAN_DOZE} scan_mode_t;
    typedef enum logic [1:0] {REC_QUAL, REC_EXTRA, REC_PROBE} uv_rec_t;
endpackage

// ---- hw/cell_voltage_protection.sv ----
/*
 * Cell voltage protection sequencer: scan pacing, shared qualification
 * timers, flags, lockouts, load probing and automatic switch control.
 * Assumes cell codes and die temperature are valid on scan_done, and that
 * current direction and host bits come from logic on the same clock.
 */
`timescale 1ns/10ps
`include "cvp_defs.svh"
module cell_voltage_protection
    import cvp_pkg::*;
#(
    parameter int NCELL      = 8,
    parameter int CYC_PER_US = `CVP_CYC_PER_US
)
(
    input  wire logic               clk,
    input  wire logic               rst_b,
    output logic                    scan_start,
    input  wire logic               scan_done,
    input  wire logic [NCELL*12-1:0] cell_codes,
    input  wire logic [11:0]        die_temp_code,
    input  wire logic               charging,
    input  wire logic               discharging,
    input  wire logic [11:0]        high_cell_level,
    input  wire logic [11:0]        high_cell_release_level,
    input  wire logic [11:0]        low_cell_level,
    input  wire logic [11:0]        low_cell_release_level,
    input  wire logic [11:0]        sleep_level,
    input  wire logic [11:0]        high_lockout_level,
    input  wire logic [11:0]        low_lockout_level,
    input  wire logic [11:0]        charge_done_level,
    input  wire logic [11:0]        low_charge_level,
    input  wire logic [11:0]        die_overheat_level,
    input  wire logic [11:0]        high_cell_delay,
    input  wire logic [11:0]        low_cell_delay,
    input  wire logic [11:0]        sleep_delay,
    input  wire logic [3:0]         idle_period,
    input  wire logic [3:0]         load_probe_width,
    input  wire logic               probe_high,
    input  wire logic               host_switch_control,
    input  wire logic               host_charge_on,
    input  wire logic               host_precharge_on,
    input  wire logic               host_discharge_on,
    input  wire logic               precharge_enable,
    input  wire logic               charge_on_during_high,
    input  wire logic               discharge_on_during_low,
    input  wire logic               lockout_power_down_select,
    input  wire logic               thermistor2_fet_select,
    input  wire logic               thermal_input_gain,
    output logic                    charge_switch,
    output logic                    precharge_switch,
    output logic                    discharge_switch,
    output logic                    high_cell_flag,
    output logic                    low_cell_flag,
    output logic                    sleep_flag,
    output logic                    high_cell_lockout_flag,
    output logic                    low_cell_lockout_flag,
    output logic                    charge_done_flag,
    output logic                    charge_done_out_n,
    output logic                    fuse_trip_output,
    output logic                    shutdown_out_n,
    output logic                    load_probe_output,
    output logic                    sleep_enter,
    output logic                    power_down,
    output logic                    die_overheat_flag,
    output scan_mode_t              scan_mode,
    output logic                    xt2_fet_mode,
    output logic                    temp_gain_two
);

    logic [7:0]  cyc_cnt;
    logic [9:0]  us_cnt;
    logic [9:0]  ms_cnt;
    logic [5:0]  s_cnt;
    logic        us_tick;
    logic        ms_tick;
    logic        s_tick;
    logic        min_tick;
    logic [3:0]  ticks;
    logic [3:0]  idle_min;
    logic [9:0]  scan_ms;
    logic [9:0]  scan_last;
    logic [NCELL-1:0] c_ov, c_ovr, c_uv, c_uvr, c_slp, c_high_cell_lockout_flag, c_low_cell_lockout_flag;
    logic [NCELL-1:0] c_eoc, c_eocl, c_lvc;
    logic [11:0] eoc_low;
    logic        any_ov, all_ovr, any_uv, all_uvr, any_slp;
    logic        any_eoc, all_eocl, any_lvc;
    logic [2:0]  qual_cond;
    logic [2:0]  qual_done;
    logic [11:0] qual_dly [3];
    logic [2:0]  low_cell_lockout_flag_cnt;
    uv_rec_t     uv_rec;
    logic [1:0]  extra_s;
    logic [8:0]  probe_ms;
    logic        probe_s1, probe_s2;
    logic        probe_seen;
    logic        pre_sel;
    logic        chg_auto, dis_auto;

    // Free-running timebase; qualification ticks come from here, not from crossings
    assign us_tick  = cyc_cnt == 8'(CYC_PER_US - 1);
    assign ms_tick  = us_tick && us_cnt == 10'(`CVP_US_PER_MS - 1);
    assign s_tick   = ms_tick && ms_cnt == 10'(`CVP_MS_PER_S - 1);
    assign min_tick = s_tick && s_cnt == 6'(`CVP_S_PER_MIN - 1);
    assign ticks    = {min_tick, s_tick, ms_tick, us_tick};

    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            cyc_cnt <= 8'h00;
            us_cnt  <= 10'h000;
            ms_cnt  <= 10'h000;
            s_cnt   <= 6'h00;
        end
        else
        begin
            cyc_cnt <= us_tick ? 8'h00 : cyc_cnt + 8'h01;
            if (us_tick)
                us_cnt <= ms_tick ? 10'h000 : us_cnt + 10'h001;
            if (ms_tick)
                ms_cnt <= s_tick ? 10'h000 : ms_cnt + 10'h001;
            if (s_tick)
                s_cnt <= min_tick ? 6'h00 : s_cnt + 6'h01;
        end

    // Scan mode moves only with idle time; faults have no say in it
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            scan_mode <= SCAN_NORMAL;
            idle_min  <= 4'h0;
        end
        else if (charging || discharging)
        begin
            scan_mode <= SCAN_NORMAL;
            idle_min  <= 4'h0;
        end
        else if (min_tick && scan_mode != SCAN_DOZE)
        begin
            if (idle_min == idle_period)
            begin
                idle_min  <= 4'h0;
                scan_mode <= scan_mode == SCAN_NORMAL ? SCAN_IDLE : SCAN_DOZE;
            end
            else
                idle_min <= idle_min + 4'h1;
        end

    // Scan pacing in milliseconds
    always_comb
        unique case (scan_mode)
            SCAN_NORMAL: scan_last = 10'(`CVP_SCAN_NORM_MS - 1);
            SCAN_IDLE:   scan_last = 10'(`CVP_SCAN_IDLE_MS - 1);
            SCAN_DOZE:   scan_last = 10'(`CVP_SCAN_DOZE_MS - 1);
            default:     scan_last = 10'(`CVP_SCAN_NORM_MS - 1);
        endcase

    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            scan_ms    <= 10'h000;
            scan_start <= 1'b0;
        end
        else
        begin
            scan_start <= ms_tick && scan_ms >= scan_last;
            if (ms_tick)
                scan_ms <= scan_ms >= scan_last ? 10'h000 : scan_ms + 10'h001;
        end

    // Per-cell comparisons against independent thresholds
    assign eoc_low = charge_done_level >= 12'(`CVP_EOC_HYST_CODE)
                   ? charge_done_level - 12'(`CVP_EOC_HYST_CODE) : 12'h000;
    for (genvar gi = 0; gi < NCELL; gi++)
    begin : g_cell
        logic [11:0] cv;
        assign cv         = cell_codes[gi*12 +: 12];
        assign c_ov[gi]   = cv > high_cell_level;
        assign c_ovr[gi]  = cv < high_cell_release_level;
        assign c_uv[gi]   = cv < low_cell_level;
        assign c_uvr[gi]  = cv > low_cell_release_level;
        assign c_slp[gi]  = cv < sleep_level;
        assign c_high_cell_lockout_flag[gi] = cv >= high_lockout_level;
        assign c_low_cell_lockout_flag[gi] = cv < low_lockout_level;
        assign c_eoc[gi]  = cv > charge_done_level;
        assign c_eocl[gi] = cv < eoc_low;
        assign c_lvc[gi]  = cv < low_charge_level;
    end

    // Scan summaries hold until the next scan so timers see a steady level
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            {any_ov, all_ovr, any_uv, all_uvr, any_slp} <= 5'h00;
            {any_eoc, all_eocl, any_lvc} <= 3'h0;
        end
        else if (scan_done)
        begin
            {any_ov, all_ovr, any_uv, all_uvr, any_slp} <=
                {|c_ov, &c_ovr, |c_uv, &c_uvr, |c_slp};
            {any_eoc, all_eocl, any_lvc} <= {|c_eoc, &c_eocl, |c_lvc};
        end

    // One shared timer per fault kind; for overvoltage and undervoltage it doubles as the recovery timer
    assign qual_cond[0] = high_cell_flag ? all_ovr : any_ov;
    assign qual_cond[1] = low_cell_flag ? (all_uvr && uv_rec == REC_QUAL) : any_uv;
    assign qual_cond[2] = any_slp && !sleep_flag;
    assign qual_dly[0]  = high_cell_delay;
    assign qual_dly[1]  = low_cell_delay;
    assign qual_dly[2]  = sleep_delay;
    for (genvar gq = 0; gq < 3; gq++)
    begin : g_qual
        logic [10:0] cnt;
        logic [1:0]  scale;
        assign scale         = qual_dly[gq][`CVP_DLY_SCALE_MSB:`CVP_DLY_SCALE_LSB];
        assign qual_done[gq] = qual_cond[gq] && cnt > {1'b0, qual_dly[gq][9:0]};
        always_ff @(posedge clk or negedge rst_b)
            if (!rst_b)
                cnt <= 11'h000;
            else if (!qual_cond[gq] || qual_done[gq])
                cnt <= 11'h000;
            else if (ticks[scale])
                cnt <= cnt + 11'h001;
    end

    // High-cell flag: set on qualified overvoltage, cleared on qualified release
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            high_cell_flag <= 1'b0;
        else if (qual_done[0])
            high_cell_flag <= !high_cell_flag;

    // Sleep bit and lockout flags are sticky until reset
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            sleep_flag             <= 1'b0;
            high_cell_lockout_flag <= 1'b0;
            low_cell_lockout_flag  <= 1'b0;
            low_cell_lockout_flag_cnt               <= 3'h0;
        end
        else
        begin
            if (qual_done[2])
                sleep_flag <= 1'b1;
            if (scan_done && |c_high_cell_lockout_flag)
                high_cell_lockout_flag <= 1'b1;
            if (scan_done)
            begin
                low_cell_lockout_flag_cnt <= |c_low_cell_lockout_flag ? (low_cell_lockout_flag_cnt == 3'(`CVP_LOCKOUT_SCANS) ? low_cell_lockout_flag_cnt
                                       : low_cell_lockout_flag_cnt + 3'h1) : 3'h0;
                if (|c_low_cell_lockout_flag && low_cell_lockout_flag_cnt == 3'(`CVP_LOCKOUT_SCANS - 1))
                    low_cell_lockout_flag <= 1'b1;
            end
        end

    // Low-cell flag and load-probe recovery sequence
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            probe_s1 <= 1'b0;
            probe_s2 <= 1'b0;
        end
        else
        begin
            probe_s1 <= probe_high;
            probe_s2 <= probe_s1;
        end

    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            low_cell_flag     <= 1'b0;
            uv_rec            <= REC_QUAL;
            extra_s           <= 2'h0;
            probe_ms          <= 9'h000;
            probe_seen        <= 1'b0;
            load_probe_output <= 1'b0;
        end
        else if (!low_cell_flag)
        begin
            uv_rec            <= REC_QUAL;
            load_probe_output <= 1'b0;
            if (qual_done[1])
                low_cell_flag <= 1'b1;
        end
        else if (!all_uvr)
        begin
            uv_rec            <= REC_QUAL; // Cells fell back; restart recovery
            load_probe_output <= 1'b0;
        end
        else
            unique case (uv_rec)
                REC_QUAL:
                    if (qual_done[1])
                    begin
                        uv_rec  <= REC_EXTRA;
                        extra_s <= 2'h0;
                    end
                REC_EXTRA:
                    if (s_tick)
                    begin
                        extra_s <= extra_s + 2'h1;
                        if (extra_s == 2'(`CVP_UV_EXTRA_S - 1))
                        begin
                            uv_rec   <= REC_PROBE;
                            probe_ms <= 9'h000;
                        end
                    end
                REC_PROBE:
                    if (ms_tick)
                    begin
                        probe_ms <= probe_ms == 9'(`CVP_PROBE_PERIOD_MS - 1)
                                  ? 9'h000 : probe_ms + 9'h001;
                        load_probe_output <= probe_ms < {5'h00, load_probe_width};
                        if (load_probe_output)
                            probe_seen <= probe_s2;
                        if (probe_ms == {5'h00, load_probe_width} && load_probe_width != 4'h0
                            && probe_seen)
                            low_cell_flag <= 1'b0;
                    end
            endcase

    // End-of-charge flag with hysteresis
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            charge_done_flag <= 1'b0;
        else if (scan_done && charging && |c_eoc)
            charge_done_flag <= 1'b1;
        else if (scan_done && &c_eocl)
            charge_done_flag <= 1'b0;

    // Die over-temperature and temperature front-end settings
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            die_overheat_flag <= 1'b0;
            xt2_fet_mode      <= 1'b0;
            temp_gain_two     <= !`CVP_THERMAL_INPUT_GAIN_RST;
        end
        else
        begin
            if (scan_done)
                die_overheat_flag <= die_temp_code > die_overheat_level;
            xt2_fet_mode  <= thermistor2_fet_select;
            temp_gain_two <= !thermal_input_gain;
        end

    // Automatic switch wishes; high lockout overrides host control, low lockout only with lockout_power_down_select
    assign pre_sel  = precharge_enable && any_lvc;
    assign chg_auto = (!high_cell_flag || (charge_on_during_high && discharging))
                      && !sleep_flag && !die_overheat_flag;
    assign dis_auto = (!low_cell_flag || (discharge_on_during_low && charging))
                      && !sleep_flag && !low_cell_lockout_flag && !die_overheat_flag;

    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            charge_switch    <= 1'b0;
            precharge_switch <= 1'b0;
            discharge_switch <= 1'b0;
        end
        else if (host_switch_control)
        begin
            charge_switch    <= host_charge_on && !high_cell_lockout_flag;
            precharge_switch <= host_precharge_on && !high_cell_lockout_flag;
            discharge_switch <= host_discharge_on
                                && !(low_cell_lockout_flag && lockout_power_down_select);
        end
        else
        begin
            charge_switch    <= chg_auto && !pre_sel && !high_cell_lockout_flag;
            precharge_switch <= chg_auto && pre_sel && !high_cell_lockout_flag;
            discharge_switch <= dis_auto;
        end

    assign charge_done_out_n = !charge_done_flag;
    assign fuse_trip_output  = high_cell_lockout_flag;
    assign shutdown_out_n    = !low_cell_lockout_flag;
    assign sleep_enter       = sleep_flag && !host_switch_control;
    assign power_down        = low_cell_lockout_flag && lockout_power_down_select;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_high_cell_lockout_flag_cut;
        $rose(high_cell_lockout_flag) |=> !charge_switch && !precharge_switch;
    endproperty
    a_high_cell_lockout_flag_cut: assert property (p_high_cell_lockout_flag_cut) else $error("lockout left charge on");
    property p_high_cell_lockout_flag_cause;
        $rose(high_cell_lockout_flag) |-> $past(scan_done);
    endproperty
    a_high_cell_lockout_flag_cause: assert property (p_high_cell_lockout_flag_cause) else $error("lockout without scan");
    property p_ov_chg;
        high_cell_flag && !host_switch_control && !discharging |=> !charge_switch;
    endproperty
    a_ov_chg: assert property (p_ov_chg) else $error("charge on in overvoltage");
    property p_uv_dis;
        low_cell_flag && !host_switch_control && !charging |=> !discharge_switch;
    endproperty
    a_uv_dis: assert property (p_uv_dis) else $error("discharge on in undervoltage");
    property p_low_cell_lockout_flag_count;
        $rose(low_cell_lockout_flag) |-> $past(low_cell_lockout_flag_cnt) == 3'h4 && $past(scan_done);
    endproperty
    a_low_cell_lockout_flag_count: assert property (p_low_cell_lockout_flag_count) else $error("lockout scan count");
    property p_ov_qual;
        $rose(high_cell_flag) |-> $past(qual_done[0]) && $past(any_ov);
    endproperty
    a_ov_qual: assert property (p_ov_qual) else $error("unqualified overvoltage");
    property p_eoc;
        $rose(charge_done_flag) |-> $past(charging) && $past(scan_done);
    endproperty
    a_eoc: assert property (p_eoc) else $error("charge done outside charge");
    property p_probe;
        load_probe_output |-> uv_rec == REC_PROBE && load_probe_width != 4'h0;
    endproperty
    a_probe: assert property (p_probe) else $error("probe pulse out of place");
    property p_sleep;
        sleep_flag && !host_switch_control |=> !charge_switch && !discharge_switch;
    endproperty
    a_sleep: assert property (p_sleep) else $error("switch on in sleep");
    property p_scan_tick;
        scan_start |-> $past(ms_tick);
    endproperty
    a_scan_tick: assert property (p_scan_tick) else $error("scan off ms grid");

    c_ov_set: cover property ($rose(high_cell_flag));
    c_uv_clear: cover property ($fell(low_cell_flag));
    c_doze: cover property (scan_mode == SCAN_DOZE && scan_start);
    c_lockout: cover property ($rose(low_cell_lockout_flag));

endmodule

// ---- bench/cell_front_model.sv ----
/* Front end and cell stack model: answers each scan request with cell codes.
   Assumes the sequencer clock; the bench may also request a scan on its own. */
`timescale 1ns/10ps
module cell_front_model
#(
    parameter int NCELL = 8
)
(
    input  wire logic                clk,
    input  wire logic                scan_start,
    input  wire logic                kick,
    input  wire logic [NCELL*12-1:0] cells_in,
    output logic                     scan_done,
    output logic [NCELL*12-1:0]      cell_codes,
    output logic [11:0]              die_temp_code
);
    logic [1:0] pend_reg = 2'h0;
    // Two-cycle conversion, so results never land on the request edge
    always @(posedge clk)
    begin
        pend_reg <= {pend_reg[0], scan_start | kick};
    end
    assign scan_done = pend_reg[1];
    // Codes are scrambled outside the done pulse to expose late sampling
    assign cell_codes = scan_done ? cells_in : ~cells_in;
    assign die_temp_code = scan_done ? 12'h100 : 12'hEFF;
endmodule

// ---- bench/tb_top.sv ----
/* Self-checking bench of the protection sequencer with a fast timebase.
   Assumes the front-end model and the design share one 200 MHz clock. */
`timescale 1ns/10ps
module tb_top
    import cvp_pkg::*;
;
    logic clk = 1'b0, rst_b = 1'b0, kick = 1'b0, charging = 1'b0, discharging = 1'b0;
    logic probe_high = 1'b0, host_switch_control = 1'b0, host_charge_on = 1'b0;
    logic host_precharge_on = 1'b0, host_discharge_on = 1'b0, precharge_enable = 1'b0;
    logic charge_on_during_high = 1'b0, discharge_on_during_low = 1'b0;
    logic lockout_power_down_select = 1'b0, thermistor2_fet_select = 1'b0;
    logic thermal_input_gain = 1'b0;
    logic [11:0] high_cell_level = 12'hA00, high_cell_release_level = 12'h980;
    logic [11:0] low_cell_level = 12'h600, low_cell_release_level = 12'h680;
    logic [11:0] sleep_level = 12'h100, high_lockout_level = 12'hC00;
    logic [11:0] low_lockout_level = 12'h400, charge_done_level = 12'h900;
    logic [11:0] low_charge_level = 12'h500, die_overheat_level = 12'hFFF;
    logic [11:0] high_cell_delay = 12'h004, low_cell_delay = 12'h004, sleep_delay = 12'h004;
    logic [3:0]  idle_period = 4'h0, load_probe_width = 4'h2;
    logic [95:0] cells = {8{12'h800}};
    logic [95:0] cell_codes;
    logic [11:0] die_temp_code;
    logic scan_start, scan_done, charge_switch, precharge_switch, discharge_switch;
    logic high_cell_flag, low_cell_flag, sleep_flag, high_cell_lockout_flag;
    logic low_cell_lockout_flag, charge_done_flag, charge_done_out_n, fuse_trip_output;
    logic shutdown_out_n, load_probe_output, sleep_enter, power_down, die_overheat_flag;
    logic xt2_fet_mode, temp_gain_two;
    scan_mode_t scan_mode;
    int error_cnt = 0;
    int cmp_count = 0;

    // Timebase of two cycles a microsecond keeps qualification short
    cell_voltage_protection #(.NCELL(8), .CYC_PER_US(2)) u_dut (.*);
    cell_front_model #(.NCELL(8)) u_front (.clk, .scan_start, .kick, .cells_in(cells),
        .scan_done, .cell_codes, .die_temp_code);

    always #2.5 clk = ~clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        if (seen !== exp)
            error_cnt++;
    endtask

    // Lets n edges pass, then steps off the last one so registered outputs have settled
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Requests n scans with cell 0 at c0 and the rest nominal
    task automatic scan(input logic [11:0] c0, input int n);
        repeat (n)
        begin
            @(posedge clk);
            cells <= {{7{12'h800}}, c0};
            kick <= 1'b1;
            @(posedge clk);
            kick <= 1'b0;
            repeat (4) @(posedge clk);
        end
        #1;
    endtask

    task automatic do_reset;
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check(16'({charge_switch, high_cell_flag, charge_done_out_n, shutdown_out_n,
            temp_gain_two}), 16'h0007);
        @(posedge clk);
        rst_b <= 1'b1;
        scan(12'h800, 2);
        check(16'({charge_switch, discharge_switch}), 16'h0003);
    endtask

    task automatic t_ov;
        scan(12'hA80, 1);
        check(16'(high_cell_flag), 16'h0000);
        settle(30);
        check(16'({high_cell_flag, charge_switch, discharge_switch}), 16'h0005);
        @(posedge clk);
        charge_on_during_high <= 1'b1;
        discharging <= 1'b1;
        settle(4);
        check(16'(charge_switch), 16'h0001);
        @(posedge clk);
        discharging <= 1'b0;
        settle(4);
        check(16'(charge_switch), 16'h0000);
        @(posedge clk);
        charge_on_during_high <= 1'b0;
        scan(12'h900, 1);
        check(16'(high_cell_flag), 16'h0001);
        settle(30);
        check(16'({high_cell_flag, charge_switch}), 16'h0001);
        $display("overvoltage test done");
    endtask

    task automatic t_eoc;
        charging <= 1'b1;
        scan(12'h980, 1);
        check(16'({charge_done_flag, charge_done_out_n}), 16'h0002);
        scan(12'h8CE, 1);
        check(16'({charge_done_flag, charge_done_out_n}), 16'h0002);
        scan(12'h890, 1);
        check(16'({charge_done_flag, charge_done_out_n}), 16'h0001);
        @(posedge clk);
        charging <= 1'b0;
        $display("charge done test done");
    endtask

    task automatic t_uv;
        precharge_enable <= 1'b1;
        scan(12'h480, 1);
        settle(30);
        check(16'({low_cell_flag, discharge_switch}), 16'h0002);
        check(16'({precharge_switch, charge_switch}), 16'h0002);
        // Charge current lets the discharge path close again while the cell is low
        @(posedge clk);
        discharge_on_during_low <= 1'b1;
        charging <= 1'b1;
        settle(4);
        check(16'(discharge_switch), 16'h0001);
        @(posedge clk);
        charging <= 1'b0;
        settle(4);
        check(16'(discharge_switch), 16'h0000);
        $display("undervoltage test done");
    endtask

    task automatic t_low_cell_lockout_flag;
        @(posedge clk);
        lockout_power_down_select <= 1'b1;
        scan(12'h300, 4);
        check(16'({low_cell_lockout_flag, shutdown_out_n, power_down}), 16'h0002);
        scan(12'h300, 1);
        check(16'({low_cell_lockout_flag, shutdown_out_n, power_down}), 16'h0005);
        check(16'({sleep_flag, precharge_switch}), 16'h0001);
        // A cell below the sleep level must open every charge path once qualified
        scan(12'h080, 1);
        settle(30);
        check(16'({sleep_flag, sleep_enter, precharge_switch, charge_switch}), 16'h000C);
        $display("low lockout test done");
    endtask

    task automatic t_high_cell_lockout_flag;
        @(posedge clk);
        die_overheat_level <= 12'h0FF;
        host_switch_control <= 1'b1;
        host_charge_on <= 1'b1;
        thermistor2_fet_select <= 1'b1;
        thermal_input_gain <= 1'b1;
        scan(12'h800, 1);
        check(16'({charge_switch, precharge_switch, discharge_switch}), 16'h0004);
        check(16'({xt2_fet_mode, temp_gain_two}), 16'h0002);
        check(16'(die_overheat_flag), 16'h0001);
        scan(12'hC00, 1);
        check(16'({high_cell_lockout_flag, fuse_trip_output, charge_switch}), 16'h0006);
        $display("high lockout test done");
    endtask

    task automatic complete_run;
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Main sequence; sticky faults are cleared by a fresh reset
    initial
    begin
        do_reset;
        t_ov;
        t_eoc;
        t_uv;
        do_reset;
        t_low_cell_lockout_flag;
        do_reset;
        t_high_cell_lockout_flag;
        complete_run;
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        complete_run;
    end
endmodule
